// *** core/ude_device.sv ***
// How it works
// RULE1: Modem control bit drives request-to-send active
// RULE2: Request-to-send high on reset, loop, cleared
// RULE3: FIFO mode picks DMA mode; else 0
// RULE4: Mode 1 needs FIFO-enable and DMA-select set
// RULE5: Mode 0: receive ready low with data
// RULE6: Mode 0: receive ready high when empty
// RULE7: Mode 1: receive ready low on trigger/timeout
// RULE8: Mode 1: stays low until fully empty
// RULE9: Mode 0: DMA does single transfers
// RULE10: Receive mode 1: DMA bursts until empty
// RULE11: Transmit mode 1: DMA bursts until full
// RULE12: Serial output marks high after master reset
// RULE13: Selected plus either strobe writes register
// RULE14: Host holds unused strobe inactive
// RULE15: Mode 0: transmit ready low while empty
`timescale 1ns/1ps
module ude_device
  import ude_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Link to host, DMA and modem
  ude_link_if.dev         link,
  // Receive side status from the receiver
  input  wire logic       user_rx_empty,
  input  wire logic       user_rx_trigger,
  input  wire logic       user_rx_timeout,
  // Transmit side status and serial bit from the transmitter
  input  wire logic       user_tx_empty,
  input  wire logic       user_tx_full,
  input  wire logic       user_tx_serial,
  // Transmit character load
  output      logic       user_tx_load,
  output      logic [7:0] user_tx_data,
  // Mode and reset state and serial input for the rest of the element
  output      logic       user_fifo_enable,
  output      logic       user_dma_mode1,
  output      logic       user_loop_mode,
  output      logic       user_master_reset,
  output      logic       user_serial_rx
);

  function automatic logic hit(input logic [2:0] a, input logic [2:0] ofs);
    hit = (a == ofs);
  endfunction

  // Pins come from another party: two flops before any logic
  localparam int SW = 16;
  logic [SW-1:0] pin_raw;
  logic [SW-1:0] pin_sync;
  logic [SW-1:0] pin_init;

  assign pin_raw = {link.serial_rx_line, link.master_reset_in,
                    link.write_strobe_lo_active, link.write_strobe_hi_active,
                    link.chip_select, link.reg_addr, link.wdata};
  // Idle values: serial idle high, first strobe idle high
  assign pin_init = {1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 3'h0, 8'h00};

  ude_sync #(
    .W (SW)
  ) u_pin_sync (
    .clk      (clk),
    .resetn   (resetn),
    .init_val (pin_init),
    .din      (pin_raw),
    .dout     (pin_sync)
  );

  logic       s_serial_rx;
  logic       s_mreset;
  logic       s_wr_lo;
  logic       s_wr_hi_n;
  logic       s_cs;
  logic [2:0] s_addr;
  logic [7:0] s_data;

  assign {s_serial_rx, s_mreset, s_wr_lo, s_wr_hi_n, s_cs, s_addr, s_data} = pin_sync;

  // Write decode state
  logic       wr_level;
  logic       wr_edge;
  logic       wr_prev_reg;
  logic       wr_prev_next;

  // Control registers
  logic       fifo_en_reg;
  logic       fifo_en_next;
  logic       dma_sel_reg;
  logic       dma_sel_next;
  logic       rts_bit_reg;
  logic       rts_bit_next;
  logic       loop_reg;
  logic       loop_next;
  logic       tx_load_reg;
  logic       tx_load_next;
  logic [7:0] tx_data_reg;
  logic [7:0] tx_data_next;

  // RULE13: either strobe while selected
  assign wr_level = s_cs & (~s_wr_hi_n | s_wr_lo);
  assign wr_edge  = wr_level & ~wr_prev_reg;

  always_comb begin
    wr_prev_next = wr_level;
    fifo_en_next = fifo_en_reg;
    dma_sel_next = dma_sel_reg;
    rts_bit_next = rts_bit_reg;
    loop_next    = loop_reg;
    tx_load_next = 1'b0;
    tx_data_next = tx_data_reg;
    if (s_mreset) begin
      fifo_en_next = CTRL_RESET[FIFO_ENABLE_BIT];
      dma_sel_next = CTRL_RESET[DMA_MODE_SELECT_BIT];
      rts_bit_next = CTRL_RESET[MODEM_RTS_BIT];
      loop_next    = CTRL_RESET[MODEM_LOOP_BIT];
    end else if (wr_edge) begin
      // RULE13: one write per strobe assertion
      if (hit(s_addr, OFS_TX_DATA)) begin
        tx_load_next = 1'b1;
        tx_data_next = s_data;
      end
      if (hit(s_addr, OFS_FIFO_CTRL)) begin
        fifo_en_next = s_data[FIFO_ENABLE_BIT];
        dma_sel_next = s_data[DMA_MODE_SELECT_BIT];
      end
      if (hit(s_addr, OFS_MODEM_CTRL)) begin
        // RULE1: software sets request-to-send bit
        rts_bit_next = s_data[MODEM_RTS_BIT];
        loop_next    = s_data[MODEM_LOOP_BIT];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_prev_reg <= 1'b0;
      fifo_en_reg <= 1'b0;
      dma_sel_reg <= 1'b0;
      rts_bit_reg <= 1'b0;
      loop_reg    <= 1'b0;
      tx_load_reg <= 1'b0;
      tx_data_reg <= 8'h00;
    end else begin
      wr_prev_reg <= wr_prev_next;
      fifo_en_reg <= fifo_en_next;
      dma_sel_reg <= dma_sel_next;
      rts_bit_reg <= rts_bit_next;
      loop_reg    <= loop_next;
      tx_load_reg <= tx_load_next;
      tx_data_reg <= tx_data_next;
    end
  end

  // RULE3: select bit only counts in FIFO mode
  // RULE4: mode 1 needs both bits set
  logic dma_mode1;
  assign dma_mode1 = fifo_en_reg & dma_sel_reg;

  // DMA request and line output state
  logic rx_hold_reg;
  logic rx_hold_next;
  logic tx_hold_reg;
  logic tx_hold_next;
  logic rx_req_n_reg;
  logic rx_req_n_next;
  logic tx_req_n_reg;
  logic tx_req_n_next;
  logic rts_n_reg;
  logic rts_n_next;
  logic serial_tx_line_reg;
  logic serial_tx_line_next;

  always_comb begin
    rx_hold_next  = rx_hold_reg;
    tx_hold_next  = tx_hold_reg;
    rx_req_n_next = 1'b1;
    tx_req_n_next = 1'b1;
    // RULE8: clear only once fully drained
    if (user_rx_empty) begin
      rx_hold_next = 1'b0;
    end
    // RULE7: trigger or timeout arms it; set wins
    if (dma_mode1 && (user_rx_trigger || user_rx_timeout) && !user_rx_empty) begin
      rx_hold_next = 1'b1;
    end
    // Transmit burst runs from empty until full
    if (user_tx_full) begin
      tx_hold_next = 1'b0;
    end
    if (dma_mode1 && user_tx_empty) begin
      tx_hold_next = 1'b1;
    end
    if (!dma_mode1) begin
      rx_hold_next = 1'b0;
      tx_hold_next = 1'b0;
    end
    if (dma_mode1) begin
      // RULE10: low for the whole drain burst
      rx_req_n_next = ~rx_hold_next;
      // RULE11: low for the whole fill burst
      tx_req_n_next = ~tx_hold_next;
    end else begin
      // RULE5: low with any character held
      // RULE6: high when nothing is left
      // RULE9: one request per character
      rx_req_n_next = user_rx_empty;
      // RULE15: low while transmit side empty
      tx_req_n_next = ~user_tx_empty;
    end
    // RULE2: inactive high in reset, loop or bit clear
    rts_n_next = ~(rts_bit_next & ~loop_next & ~s_mreset);
    // RULE12: marking while reset; loop also holds it idle
    serial_tx_line_next = (s_mreset || loop_next) ? 1'b1 : user_tx_serial;
    if (s_mreset) begin
      rx_hold_next  = 1'b0;
      tx_hold_next  = 1'b0;
      rx_req_n_next = 1'b1;
      tx_req_n_next = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_hold_reg  <= 1'b0;
      tx_hold_reg  <= 1'b0;
      rx_req_n_reg <= 1'b1;
      tx_req_n_reg <= 1'b1;
      rts_n_reg    <= 1'b1;
      serial_tx_line_reg     <= 1'b1;
    end else begin
      rx_hold_reg  <= rx_hold_next;
      tx_hold_reg  <= tx_hold_next;
      rx_req_n_reg <= rx_req_n_next;
      tx_req_n_reg <= tx_req_n_next;
      rts_n_reg    <= rts_n_next;
      serial_tx_line_reg     <= serial_tx_line_next;
    end
  end

  assign link.rx_dma_request_n  = rx_req_n_reg;
  assign link.tx_dma_request_n  = tx_req_n_reg;
  assign link.request_to_send_n = rts_n_reg;
  assign link.serial_tx_line    = serial_tx_line_reg;

  assign user_tx_load      = tx_load_reg;
  assign user_tx_data      = tx_data_reg;
  assign user_fifo_enable  = fifo_en_reg;
  assign user_dma_mode1    = dma_mode1;
  assign user_loop_mode    = loop_reg;
  assign user_master_reset = s_mreset;
  assign user_serial_rx    = s_serial_rx;

endmodule

// *** core/ude_host.sv ***
`timescale 1ns/1ps
module ude_host
  import ude_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output      logic [31:0] avs_readdata,
  output      logic        avs_waitrequest,
  // Link to the serial element
  ude_link_if.host         link,
  // Serial line into the element
  input  wire logic        serial_rx_in
);

  // Status pins from the element are synchronised first
  logic [3:0] st_sync;
  logic [3:0] st_raw;

  assign st_raw = {link.serial_tx_line, link.request_to_send_n,
                   link.tx_dma_request_n, link.rx_dma_request_n};

  ude_sync #(
    .W (4)
  ) u_status_sync (
    .clk      (clk),
    .resetn   (resetn),
    .init_val (4'hF),
    .din      (st_raw),
    .dout     (st_sync)
  );

  ude_host_state_e state_reg;
  ude_host_state_e state_next;
  logic [7:0]  cnt_reg;
  logic [7:0]  cnt_next;
  logic [7:0]  mr_cnt_reg;
  logic [7:0]  mr_cnt_next;
  logic        cs_reg;
  logic        cs_next;
  logic [2:0]  addr_reg;
  logic [2:0]  addr_next;
  logic [7:0]  data_reg;
  logic [7:0]  data_next;
  logic        sel_reg;
  logic        sel_next;
  logic        wr1_n_reg;
  logic        wr1_n_next;
  logic        wr2_reg;
  logic        wr2_next;
  logic        mr_reg;
  logic        mr_next;
  logic        rd_ack_reg;
  logic        rd_ack_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        busy;
  logic        wr_ok;

  assign busy  = (state_reg != HS_IDLE) || mr_reg;
  // Writes to command or control wait until the link is free
  assign wr_ok = !busy || !((avs_address == HOST_CMD) || (avs_address == HOST_CTRL));
  assign avs_waitrequest = (avs_read && !rd_ack_reg) || (avs_write && !wr_ok);

  always_comb begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    mr_cnt_next = mr_cnt_reg;
    cs_next     = cs_reg;
    addr_next   = addr_reg;
    data_next   = data_reg;
    sel_next    = sel_reg;
    wr1_n_next  = 1'b1;
    wr2_next    = 1'b0;
    mr_next     = mr_reg;
    rd_ack_next = avs_read && !rd_ack_reg;
    rdata_next  = rdata_reg;
    if (avs_read && !rd_ack_reg) begin
      rdata_next = 32'h0000_0000;
      if (avs_address == HOST_STATUS) begin
        rdata_next[4:0] = {st_sync, busy};
      end
    end
    if (mr_reg) begin
      if (mr_cnt_reg <= 8'h01) begin
        mr_next = 1'b0;
      end
      mr_cnt_next = mr_cnt_reg - 8'h01;
    end
    case (state_reg)
      HS_IDLE: begin
        cs_next = 1'b0;
        if (avs_write && !busy && avs_address == HOST_CMD) begin
          cs_next    = 1'b1;
          addr_next  = avs_writedata[CMD_ADDR_LSB +: 3];
          data_next  = avs_writedata[7:0];
          sel_next   = avs_writedata[CMD_STROBE_SEL_BIT];
          cnt_next   = DS_CYC;
          state_next = HS_SETUP;
        end else if (avs_write && !busy && avs_address == HOST_CTRL
                     && avs_writedata[CTRL_MR_BIT]) begin
          mr_next     = 1'b1;
          mr_cnt_next = MR_CYC;
        end
      end
      HS_SETUP: begin
        cnt_next = cnt_reg - 8'h01;
        if (cnt_reg <= 8'h01) begin
          cnt_next   = WR_CYC;
          state_next = HS_STROBE;
          // Strobe starts here so it stands for the whole count
          wr1_n_next = sel_reg;
          wr2_next   = sel_reg;
        end
      end
      HS_STROBE: begin
        // RULE14: only the chosen strobe moves
        wr1_n_next = sel_reg;
        wr2_next   = sel_reg;
        cnt_next   = cnt_reg - 8'h01;
        if (cnt_reg <= 8'h01) begin
          wr1_n_next = 1'b1;
          wr2_next   = 1'b0;
          cnt_next   = DH_CYC;
          state_next = HS_HOLD;
        end
      end
      HS_HOLD: begin
        cnt_next = cnt_reg - 8'h01;
        if (cnt_reg <= 8'h01) begin
          cs_next    = 1'b0;
          state_next = HS_IDLE;
        end
      end
      default: begin
        cs_next    = 1'b0;
        state_next = HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg  <= HS_IDLE;
      cnt_reg    <= 8'h00;
      mr_cnt_reg <= 8'h00;
      cs_reg     <= 1'b0;
      addr_reg   <= 3'h0;
      data_reg   <= 8'h00;
      sel_reg    <= 1'b0;
      wr1_n_reg  <= 1'b1;
      wr2_reg    <= 1'b0;
      mr_reg     <= 1'b0;
      rd_ack_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      mr_cnt_reg <= mr_cnt_next;
      cs_reg     <= cs_next;
      addr_reg   <= addr_next;
      data_reg   <= data_next;
      sel_reg    <= sel_next;
      wr1_n_reg  <= wr1_n_next;
      wr2_reg    <= wr2_next;
      mr_reg     <= mr_next;
      rd_ack_reg <= rd_ack_next;
      rdata_reg  <= rdata_next;
    end
  end

  assign avs_readdata                = rdata_reg;
  assign link.chip_select            = cs_reg;
  assign link.reg_addr               = addr_reg;
  assign link.wdata                  = data_reg;
  assign link.write_strobe_hi_active = wr1_n_reg;
  assign link.write_strobe_lo_active = wr2_reg;
  assign link.master_reset_in        = mr_reg;
  assign link.serial_rx_line         = serial_rx_in;

endmodule

// *** core/ude_link_if.sv ***
`timescale 1ns/1ps
interface ude_link_if;
  logic       chip_select;
  logic [2:0] reg_addr;
  logic [7:0] wdata;
  logic       write_strobe_hi_active;
  logic       write_strobe_lo_active;
  logic       master_reset_in;
  logic       rx_dma_request_n;
  logic       tx_dma_request_n;
  logic       request_to_send_n;
  logic       serial_tx_line;
  logic       serial_rx_line;

  modport dev (
    input  chip_select, reg_addr, wdata, write_strobe_hi_active,
    input  write_strobe_lo_active, master_reset_in, serial_rx_line,
    output rx_dma_request_n, tx_dma_request_n, request_to_send_n, serial_tx_line
  );

  modport host (
    output chip_select, reg_addr, wdata, write_strobe_hi_active,
    output write_strobe_lo_active, master_reset_in, serial_rx_line,
    input  rx_dma_request_n, tx_dma_request_n, request_to_send_n, serial_tx_line
  );
endinterface

// *** core/ude_pkg.sv ***
package ude_pkg;

  // Clock and printed times
  localparam int CLK_PERIOD_NS = 20;
  localparam int T_WR_STROBE_NS = 80;
  localparam int T_DATA_SETUP_NS = 15;
  localparam int T_DATA_HOLD_NS = 15;
  localparam int T_MASTER_RESET_NS = 1000;

  // Least times round up, never under one cycle
  localparam int WR_CYC_I = (T_WR_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DS_CYC_I = (T_DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DH_CYC_I = (T_DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MR_CYC_I = (T_MASTER_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] WR_CYC = 8'((WR_CYC_I < 1) ? 1 : WR_CYC_I);
  localparam logic [7:0] DS_CYC = 8'((DS_CYC_I < 1) ? 1 : DS_CYC_I);
  localparam logic [7:0] DH_CYC = 8'((DH_CYC_I < 1) ? 1 : DH_CYC_I);
  localparam logic [7:0] MR_CYC = 8'((MR_CYC_I < 1) ? 1 : MR_CYC_I);

  // Serial element register offsets on the parallel pins
  localparam logic [2:0] OFS_TX_DATA    = 3'h0;
  localparam logic [2:0] OFS_FIFO_CTRL  = 3'h2;
  localparam logic [2:0] OFS_MODEM_CTRL = 3'h4;

  // Field positions and reset values
  localparam int FIFO_ENABLE_BIT = 0;
  localparam int DMA_MODE_SELECT_BIT = 3;
  localparam int MODEM_RTS_BIT = 1;
  localparam int MODEM_LOOP_BIT = 4;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Host register map (Avalon byte addresses)
  localparam logic [3:0] HOST_CMD    = 4'h0;
  localparam logic [3:0] HOST_STATUS = 4'h4;
  localparam logic [3:0] HOST_CTRL   = 4'h8;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_STROBE_SEL_BIT = 16;
  localparam int CTRL_MR_BIT = 0;

  typedef enum logic [1:0] {
    HS_IDLE   = 2'b00,
    HS_SETUP  = 2'b01,
    HS_STROBE = 2'b10,
    HS_HOLD   = 2'b11
  } ude_host_state_e;

endpackage

// *** core/ude_sync.sv ***
`timescale 1ns/1ps
module ude_sync
  import ude_pkg::*;
#(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // Reset value and data
  input  wire logic [W-1:0] init_val,
  input  wire logic [W-1:0] din,
  output      logic [W-1:0] dout
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] sync_reg;
  logic [W-1:0] sync_next;
  logic         primed_reg;

  // Second stage only reads the first; nothing else does
  always_comb begin
    meta_next = din;
    sync_next = primed_reg ? meta_reg : init_val;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_reg   <= '0;
      sync_reg   <= '0;
      primed_reg <= 1'b0;
    end else begin
      meta_reg   <= meta_next;
      sync_reg   <= sync_next;
      primed_reg <= 1'b1;
    end
  end

  assign dout = primed_reg ? sync_reg : init_val;
endmodule

// *** testbench/uart_dma_ready_and_line_outputs_test.sv ***
`timescale 1ns/1ps
module uart_dma_ready_and_line_outputs_test;
  import ude_pkg::*;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        serial_rx_in = 1'b1;
  logic        tx_serial = 1'b1;
  logic [4:0]  ui = 5'h10;
  logic        tx_load, fifo_en, dma_mode1, loop_mode, ser_rx;
  logic [7:0]  tx_data;
  logic        mr_user;
  logic [31:0] rd;
  int          mismatches = 0;
  int          samples_checked = 0;
  int          loads = 0;
  // FIFO control, {empty, trigger, timeout, tx empty, tx full}, {rx_n, tx_n}
  logic [14:0] rows [14] = '{
    {8'h00, 5'h00, 2'h1}, {8'h00, 5'h10, 2'h3}, {8'h00, 5'h12, 2'h2},
    {8'h08, 5'h02, 2'h0}, {8'h01, 5'h00, 2'h1}, {8'h09, 5'h10, 2'h3},
    {8'h09, 5'h00, 2'h3}, {8'h09, 5'h0A, 2'h0}, {8'h09, 5'h00, 2'h0},
    {8'h09, 5'h01, 2'h1}, {8'h09, 5'h10, 2'h3}, {8'h09, 5'h04, 2'h1},
    {8'h09, 5'h10, 2'h3}, {8'h00, 5'h00, 2'h1}};

  ude_link_if link ();

  ude_host i_ude_host (.clk(clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link(link),
    .serial_rx_in(serial_rx_in));

  ude_device i_ude_device (.clk(clk), .resetn(resetn), .link(link),
    .user_rx_empty(ui[4]), .user_rx_trigger(ui[3]), .user_rx_timeout(ui[2]),
    .user_tx_empty(ui[1]), .user_tx_full(ui[0]), .user_tx_serial(tx_serial),
    .user_tx_load(tx_load), .user_tx_data(tx_data), .user_fifo_enable(fifo_en),
    .user_dma_mode1(dma_mode1), .user_loop_mode(loop_mode), .user_master_reset(mr_user),
    .user_serial_rx(ser_rx));

  ude_link_chk i_ude_link_chk (.clk(clk), .resetn(resetn), .chip_select(link.chip_select),
    .reg_addr(link.reg_addr), .wdata(link.wdata),
    .write_strobe_hi_active(link.write_strobe_hi_active),
    .write_strobe_lo_active(link.write_strobe_lo_active),
    .master_reset_in(link.master_reset_in), .request_to_send_n(link.request_to_send_n),
    .serial_tx_line(link.serial_tx_line));

  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  always @(posedge clk) begin
    if (tx_load === 1'b1) begin
      loads <= loads + 1;
    end
  end

  task automatic conclude();
    $display("Checked %0d values, %0d mismatches", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Waitrequest and read data are taken as they stood at the rising edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 500);
    if (avs_waitrequest !== 1'b0) mismatches++;
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_idle();
    do bus(1'b0, HOST_STATUS, 32'h0); while (rd[0] !== 1'b0);
    repeat (3) @(posedge clk);
  endtask

  task automatic link_wr(input logic sel, input logic [2:0] a, input logic [7:0] d);
    bus(1'b1, HOST_CMD, {15'h0, sel, 5'h0, a, d});
    wait_idle();
  endtask

  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    check("outs", 32'({link.rx_dma_request_n, link.tx_dma_request_n,
      link.request_to_send_n, link.serial_tx_line}), 32'hF);
    bus(1'b0, HOST_STATUS, 32'h0);
    check("status", rd & 32'h1F, 32'h1E);
    $display("reset test done");
    for (int i = 0; i < 14; i++) begin
      link_wr(i[0], OFS_FIFO_CTRL, rows[i][14:7]);
      ui <= rows[i][6:2];
      repeat (2) @(posedge clk);
      check("dma_req", 32'({link.rx_dma_request_n, link.tx_dma_request_n}),
        32'(rows[i][1:0]));
      check("mode1", 32'(dma_mode1), 32'(rows[i][7] & rows[i][10]));
    end
    $display("dma table done");
    ui <= 5'h10;
    tx_serial <= 1'b0;
    link_wr(1'b1, OFS_MODEM_CTRL, 8'h02);
    check("rts_on", 32'({link.request_to_send_n, link.serial_tx_line}), 32'h0);
    link_wr(1'b0, OFS_MODEM_CTRL, 8'h12);
    check("rts_loop", 32'({link.request_to_send_n, link.serial_tx_line}), 32'h3);
    check("loop", 32'(loop_mode), 32'h1);
    link_wr(1'b0, OFS_MODEM_CTRL, 8'h00);
    check("rts_off", 32'({link.request_to_send_n, link.serial_tx_line}), 32'h2);
    link_wr(1'b1, OFS_TX_DATA, 8'hA5);
    check("tx_data", 32'(tx_data), 32'hA5);
    check("loads", 32'(loads), 32'h1);
    $display("modem and data test done");
    link_wr(1'b0, OFS_MODEM_CTRL, 8'h02);
    link_wr(1'b1, OFS_FIFO_CTRL, 8'h09);
    bus(1'b1, HOST_CTRL, 32'h1);
    for (int n = 0; n < 50 && link.master_reset_in !== 1'b1; n++) @(posedge clk);
    repeat (5) @(posedge clk);
    check("mr_outs", 32'({link.request_to_send_n, link.serial_tx_line}), 32'h3);
    check("mr_user", 32'(mr_user), 32'h1);
    wait_idle();
    check("mr_modes", 32'({fifo_en, dma_mode1, link.request_to_send_n}), 32'h1);
    $display("master reset test done");
    bus(1'b1, 4'hC, 32'hFFFF_FFFF);
    bus(1'b0, 4'hC, 32'h0);
    check("unmapped", rd, 32'h0);
    serial_rx_in <= 1'b0;
    repeat (4) @(posedge clk);
    check("ser_rx", 32'(ser_rx), 32'h0);
    $display("bus test done");
    conclude();
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    conclude();
  end
endmodule

// *** testbench/ude_link_chk.sv ***
`timescale 1ns/1ps
module ude_link_chk (
  // Clock and reset
  input wire logic       clk,
  input wire logic       resetn,
  // Host side of the link
  input wire logic       chip_select,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] wdata,
  input wire logic       write_strobe_hi_active,
  input wire logic       write_strobe_lo_active,
  input wire logic       master_reset_in,
  // Device side of the link
  input wire logic       request_to_send_n,
  input wire logic       serial_tx_line
);
  logic strobe_on;

  // First strobe is active low, second active high
  assign strobe_on = !write_strobe_hi_active || write_strobe_lo_active;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Five cycles cover the two sync flops and the output flop
  rts_reset_high_a: assert property (master_reset_in [*5] |-> request_to_send_n)
    else $error("request to send low during master reset");
  serial_tx_line_reset_mark_a: assert property (master_reset_in [*5] |-> serial_tx_line)
    else $error("serial output not marking during master reset");
  one_strobe_a: assert property (!(!write_strobe_hi_active && write_strobe_lo_active))
    else $error("both write strobes active together");
  strobe_selected_a: assert property (strobe_on |-> chip_select)
    else $error("write strobe without chip select");
  select_setup_a: assert property ($rose(strobe_on) |-> $past(chip_select))
    else $error("chip select not set up before strobe");
  strobe_width_a: assert property ($rose(strobe_on) |-> strobe_on [*4])
    else $error("write strobe shorter than four cycles");
  data_held_a: assert property (strobe_on ##1 strobe_on |-> $stable(wdata) && $stable(reg_addr))
    else $error("write data or offset moved under strobe");
  hold_after_a: assert property ($fell(strobe_on) |-> chip_select && $stable(wdata))
    else $error("no hold after write strobe");
endmodule
